// >>> hw/wdpm_map.svh
// offsets, field positions, reset values and timing counts of the block
`ifndef WDPM_MAP_SVH
`define WDPM_MAP_SVH

`define ADR_POWER_CTRL     8'h00
`define ADR_WD_CTRL        8'h04
`define ADR_WD_RELOAD      8'h08
`define ADR_WD_COUNT       8'h0C
`define ADR_STATUS         8'h10

`define PC_IDLE_ARM        0
`define PC_PD_ARM          1
`define PC_SLOW            4
`define PC_IDLE_SET        5
`define PC_PD_SET          6

`define WC_REFRESH         0
`define WC_START           1
`define WC_RUNNING         2
`define WC_CAUSE           3

`define WR_SEL384          7

`define RST_POWER_CTRL     8'h00
`define RST_WD_RELOAD      8'h00

`define CLK_PERIOD_NS      40
`define OSC_EXT_NS         1000000
`define OSC_EXT_CYCLES     ((`OSC_EXT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WD_BASE_DIV        12
`define SLOW_DIV           8
`define WD_RESET_CYCLES    16
`define HW_POWERDOWN_PIN_SEQ_CYCLES    16

`endif

// >>> hw/wdpm_pkg.sv
// types shared by the watchdog and power mode block
package wdpm_pkg;

    typedef struct packed {
        logic       cyc;
        logic       stb;
        logic       we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } wb_req_t;

    typedef struct packed {
        logic sys_reset;
        logic rc_clock_sel;
        logic cpu_clk_en;
        logic periph_clk_en;
        logic osc_stop;
        logic port_float;
    } power_out_t;

    typedef enum logic [2:0] {
        MON_HOLD,
        MON_EXTEND,
        MON_RUN,
        MON_HW_POWERDOWN_PIN_SEQ,
        MON_HW_POWERDOWN_PIN_OFF
    } mon_state_t;

endpackage

// >>> hw/watchdog_power_mode_control.sv
// watchdog timer, oscillator monitor and power mode control
// How it works
// - 15-bit watchdog counting at clock/24 or /384
// - two cascaded prescalers, by two and sixteen
// - software sets only top seven counter bits
// - start by bit or pin; only reset stops it
// - unrefreshed overflow starts an internal reset
// - refresh loads reload into top seven bits
// - readable flag tells watchdog or external reset
// - watchdog frozen in idle and power-down
// - slow main oscillator selects RC, holds reset
// - oscillator recovered: extend reset one millisecond
// - after power-on, same monitoring from RC clock
// - hardware power-down exit restarts through monitor
// - idle gates cpu clock, peripherals keep running
// - idle entered by 01H then 20H
// - slow-down divides all clocks by eight
// - slow-down combines with idle: 01H, 30H
// - software power-down by 02H then 40H
// - power-down left by reset or irq0 pulse
// - hardware power-down: reset, stop, float
`timescale 1ns/1ns
`include "wdpm_map.svh"

module watchdog_power_mode_control
    import wdpm_pkg::*;
#(
    parameter int OSC_EXT_CYCLES = `OSC_EXT_CYCLES,
    parameter int WD_WIDTH       = 15,
    parameter int RELOAD_WIDTH   = 7
)(
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire wb_req_t     wb_req,
    output logic             wb_ack,
    output logic [31:0]      wb_dat_o,
    input  wire logic        watchdog_enable_pin,
    input  wire logic        hw_powerdown_pin,
    input  wire logic        ext_irq0_wake_pin,
    input  wire logic        periph_irq,
    input  wire logic        osc_below_rc,
    output power_out_t       power_out
);

    localparam int LOW_BITS = WD_WIDTH - RELOAD_WIDTH;

    logic                    ack_q;
    logic [31:0]             rdata_q;
    logic                    access;
    logic                    wr_pc;
    logic                    wr_wc;
    logic                    wr_wr;
    logic [7:0]              wdat;

    logic [7:0]              pc_q;
    logic                    idle_q;
    logic                    pd_q;
    logic                    idle_arm_q;
    logic                    pd_arm_q;
    logic                    refresh_arm_q;
    logic [RELOAD_WIDTH-1:0] reload_q;
    logic                    sel384_q;
    logic                    running_q;
    logic                    cause_q;
    logic [WD_WIDTH-1:0]     count_q;
    logic [2:0]              slow_cnt_q;
    logic                    tick;
    logic [3:0]              base_cnt_q;
    logic                    pre2_q;
    logic [3:0]              pre16_q;
    logic                    wd_inc;
    logic                    wd_ovf;
    logic                    refresh;
    logic [4:0]              wd_rst_cnt_q;
    mon_state_t              mon_q;
    logic [31:0]             mon_cnt_q;
    logic                    internal_reset;

    // bus: ack one cycle after request, write lands on the acked edge
    assign access = wb_req.cyc & wb_req.stb & ack_q;
    assign wdat   = wb_req.dat[7:0];
    assign wr_pc  = access & wb_req.we & wb_req.sel[0] & (wb_req.adr == `ADR_POWER_CTRL);
    assign wr_wc  = access & wb_req.we & wb_req.sel[0] & (wb_req.adr == `ADR_WD_CTRL);
    assign wr_wr  = access & wb_req.we & wb_req.sel[0] & (wb_req.adr == `ADR_WD_RELOAD);
    assign wb_ack = ack_q;
    assign wb_dat_o = rdata_q;

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            ack_q <= 1'b0;
        end
        else
        begin
            ack_q <= wb_req.cyc & wb_req.stb & ~ack_q;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            rdata_q <= 32'h0000_0000;
        end
        else if (wb_req.cyc & wb_req.stb & ~ack_q)
        begin
            if (wb_req.adr == `ADR_POWER_CTRL)
                rdata_q <= {24'h00_0000, pc_q};
            else if (wb_req.adr == `ADR_WD_CTRL)
                rdata_q <= {28'h000_0000, cause_q, running_q, 2'b00};
            else if (wb_req.adr == `ADR_WD_RELOAD)
                rdata_q <= {24'h00_0000, sel384_q, reload_q};
            else if (wb_req.adr == `ADR_WD_COUNT)
                rdata_q <= {17'h0_0000, count_q};
            else if (wb_req.adr == `ADR_STATUS)
                rdata_q <= {25'h000_0000, pd_q, idle_q, 2'b00, 3'(mon_q)};
            else
                rdata_q <= 32'h0000_0000;
        end
    end

    // internal reset: watchdog overflow pulse or monitor not running
    assign internal_reset = (mon_q != MON_RUN) | (wd_rst_cnt_q != 5'h00);

    // power control register and two-step mode entry
    always_ff @(posedge clock)
    begin
        if (!rst_n || internal_reset)
        begin
            pc_q       <= `RST_POWER_CTRL;
            idle_arm_q <= 1'b0;
            pd_arm_q   <= 1'b0;
        end
        else if (access)
        begin
            if (wr_pc)
                pc_q <= wdat;
            // arming survives only into the very next access
            idle_arm_q <= wr_pc & wdat[`PC_IDLE_ARM];
            pd_arm_q   <= wr_pc & wdat[`PC_PD_ARM];
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n || internal_reset)
        begin
            idle_q <= 1'b0;
        end
        else if (wr_pc & idle_arm_q & wdat[`PC_IDLE_SET])
        begin
            idle_q <= 1'b1;
        end
        else if (periph_irq)
        begin
            idle_q <= 1'b0;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n || internal_reset)
        begin
            pd_q <= 1'b0;
        end
        else if (wr_pc & pd_arm_q & wdat[`PC_PD_SET])
        begin
            pd_q <= 1'b1;
        end
        else if (!ext_irq0_wake_pin)
        begin
            pd_q <= 1'b0;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            slow_cnt_q <= 3'h0;
        end
        else
        begin
            slow_cnt_q <= slow_cnt_q + 3'h1;
        end
    end

    assign tick = pc_q[`PC_SLOW] ? (slow_cnt_q == 3'(`SLOW_DIV - 1)) : 1'b1;

    // base divider then by two, then by sixteen
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            base_cnt_q <= 4'h0;
            pre2_q     <= 1'b0;
            pre16_q    <= 4'h0;
        end
        else if (tick & ~idle_q & ~pd_q & (mon_q == MON_RUN))
        begin
            if (base_cnt_q == 4'(`WD_BASE_DIV - 1))
            begin
                base_cnt_q <= 4'h0;
                pre2_q     <= ~pre2_q;
                if (pre2_q)
                    pre16_q <= pre16_q + 4'h1;
            end
            else
            begin
                base_cnt_q <= base_cnt_q + 4'h1;
            end
        end
    end

    // one count per 24 or per 384 clocks
    // frozen while idle or powered down
    assign wd_inc = running_q & tick & ~idle_q & ~pd_q & (mon_q == MON_RUN)
                  & (base_cnt_q == 4'(`WD_BASE_DIV - 1)) & pre2_q
                  & (~sel384_q | (pre16_q == 4'hF));
    assign wd_ovf = wd_inc & (&count_q);

    // start write right after refresh write
    assign refresh = wr_wc & refresh_arm_q & wdat[`WC_START];

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            refresh_arm_q <= 1'b0;
        end
        // any other access in between cancels
        else if (access)
        begin
            refresh_arm_q <= wr_wc & wdat[`WC_REFRESH] & running_q;
        end
    end

    // only top seven bits programmable, via reload
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            reload_q <= RELOAD_WIDTH'(`RST_WD_RELOAD);
            sel384_q <= 1'b0;
        end
        else if (wr_wr)
        begin
            reload_q <= wdat[RELOAD_WIDTH-1:0];
            sel384_q <= wdat[`WR_SEL384];
        end
    end

    // started by bit or pin, cleared only by reset
    always_ff @(posedge clock)
    begin
        if (!rst_n || internal_reset)
        begin
            running_q <= 1'b0;
        end
        else if ((wr_wc & wdat[`WC_START]) | watchdog_enable_pin)
        begin
            running_q <= 1'b1;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n || !running_q)
        begin
            count_q <= '0;
        end
        // refresh loads reload, low bits cleared
        else if (refresh)
        begin
            count_q <= {reload_q, LOW_BITS'(0)};
        end
        else if (wd_inc)
        begin
            count_q <= count_q + WD_WIDTH'(1);
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            wd_rst_cnt_q <= 5'h00;
        end
        else if (wd_ovf)
        begin
            wd_rst_cnt_q <= 5'(`WD_RESET_CYCLES);
        end
        else if (wd_rst_cnt_q != 5'h00)
        begin
            wd_rst_cnt_q <= wd_rst_cnt_q - 5'h01;
        end
    end

    // cause flag, external reset clears it
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            cause_q <= 1'b0;
        end
        else if (wd_ovf)
        begin
            cause_q <= 1'b1;
        end
        else if (mon_q == MON_HOLD)
        begin
            cause_q <= 1'b0;
        end
    end

    // power-on starts held, same as a failure
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            mon_q     <= MON_HOLD;
            mon_cnt_q <= 32'h0000_0000;
        end
        else
        begin
            case (mon_q)
                MON_HOLD:
                begin
                    mon_cnt_q <= 32'h0000_0000;
                    if (!hw_powerdown_pin)
                        mon_q <= MON_HW_POWERDOWN_PIN_SEQ;
                    else if (!osc_below_rc)
                        mon_q <= MON_EXTEND;
                end
                MON_EXTEND:
                begin
                    mon_cnt_q <= mon_cnt_q + 32'h0000_0001;
                    if (!hw_powerdown_pin)
                    begin
                        mon_q     <= MON_HW_POWERDOWN_PIN_SEQ;
                        mon_cnt_q <= 32'h0000_0000;
                    end
                    else if (osc_below_rc)
                        mon_q <= MON_HOLD;
                    else if (mon_cnt_q == 32'(OSC_EXT_CYCLES - 1))
                        mon_q <= MON_RUN;
                end
                MON_RUN:
                begin
                    mon_cnt_q <= 32'h0000_0000;
                    if (!hw_powerdown_pin)
                        mon_q <= MON_HW_POWERDOWN_PIN_SEQ;
                    else if (osc_below_rc)
                        mon_q <= MON_HOLD;
                end
                MON_HW_POWERDOWN_PIN_SEQ:
                begin
                    mon_cnt_q <= mon_cnt_q + 32'h0000_0001;
                    if (mon_cnt_q == 32'(`HW_POWERDOWN_PIN_SEQ_CYCLES - 1))
                        mon_q <= MON_HW_POWERDOWN_PIN_OFF;
                end
                MON_HW_POWERDOWN_PIN_OFF:
                begin
                    mon_cnt_q <= 32'h0000_0000;
                    if (hw_powerdown_pin)
                        mon_q <= MON_HOLD;
                end
                default:
                begin
                    mon_q     <= MON_HOLD;
                    mon_cnt_q <= 32'h0000_0000;
                end
            endcase
        end
    end

    // cpu gated in idle, peripherals still ticking
    always_comb
    begin
        power_out.sys_reset     = internal_reset;
        power_out.rc_clock_sel  = (mon_q != MON_RUN);
        power_out.cpu_clk_en    = tick & ~idle_q & ~pd_q & ~internal_reset;
        power_out.periph_clk_en = tick & ~pd_q & ~internal_reset;
        power_out.osc_stop      = pd_q | (mon_q == MON_HW_POWERDOWN_PIN_OFF);
        power_out.port_float    = (mon_q == MON_HW_POWERDOWN_PIN_OFF);
    end

endmodule

// >>> testbench/wdpm_sva.sv
// concurrent checks on the watchdog and power mode ports
`timescale 1ns/1ns
module wdpm_sva
    import wdpm_pkg::*;
#(
    parameter int OSC_EXT_CYCLES = 8
)(
    input wire logic        clock,
    input wire logic        rst_n,
    input wire wb_req_t     wb_req,
    input wire logic        wb_ack,
    input wire logic [31:0] wb_dat_o,
    input wire logic        watchdog_enable_pin,
    input wire logic        hw_powerdown_pin,
    input wire logic        ext_irq0_wake_pin,
    input wire logic        periph_irq,
    input wire logic        osc_below_rc,
    input wire power_out_t  power_out
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    logic [15:0] ok_q;
    logic [5:0]  low_q;

    // edges of good oscillator while still on the rc clock
    always_ff @(posedge clock)
    begin
        if (!rst_n || !power_out.rc_clock_sel || osc_below_rc || !hw_powerdown_pin)
            ok_q <= 16'h0;
        else
            ok_q <= ok_q + 16'h1;
    end

    // saturates so a long power-down cannot wrap it
    always_ff @(posedge clock)
    begin
        if (!rst_n || hw_powerdown_pin)
            low_q <= 6'h0;
        else if (low_q != 6'h3F)
            low_q <= low_q + 6'h1;
    end

    a_ack_single: assert property (wb_ack |=> !wb_ack)
        else $error("ack longer than one cycle");
    a_ack_prompt: assert property (wb_req.cyc && wb_req.stb && !wb_ack |=> wb_ack)
        else $error("ack missing one cycle after request");
    a_rc_in_reset: assert property (power_out.rc_clock_sel |-> power_out.sys_reset)
        else $error("rc clock selected outside reset");
    a_osc_fail: assert property (osc_below_rc && !power_out.sys_reset |=>
        power_out.rc_clock_sel && power_out.sys_reset)
        else $error("slow oscillator did not force reset");
    a_extend_min: assert property ($fell(power_out.rc_clock_sel) |->
        ok_q >= OSC_EXT_CYCLES)
        else $error("reset extension too short");
    a_extend_max: assert property (power_out.rc_clock_sel |->
        ok_q <= OSC_EXT_CYCLES + 4)
        else $error("reset extension too long");
    a_hw_powerdown_pin_entry: assert property ($fell(hw_powerdown_pin) |=> power_out.sys_reset)
        else $error("power-down pin did not reset");
    a_hw_powerdown_pin_off: assert property (low_q >= 6'h14 |->
        power_out.port_float && power_out.osc_stop && power_out.sys_reset)
        else $error("power-down off state not reached");
    a_hw_powerdown_pin_exit: assert property (power_out.port_float && hw_powerdown_pin |=>
        !power_out.port_float && power_out.rc_clock_sel)
        else $error("power-down exit not via monitor");
    a_clk_gating: assert property (power_out.cpu_clk_en |-> power_out.periph_clk_en)
        else $error("cpu clocked without peripherals");
    a_stop_all: assert property (power_out.osc_stop || power_out.sys_reset |->
        !power_out.cpu_clk_en && !power_out.periph_clk_en)
        else $error("clock enable while stopped");
endmodule

// >>> testbench/board_model.sv
// board logic that drives the power-down, wake and watchdog pins
`timescale 1ns/1ns
module board_model (
    input  wire logic clock,
    input  wire logic pd_req,
    input  wire logic wake_req,
    input  wire logic wden_req,
    input  wire logic osc_bad,
    output logic      hw_powerdown_pin = 1'b1,
    output logic      ext_irq0_wake_pin = 1'b1,
    output logic      watchdog_enable_pin = 1'b0,
    output logic      osc_below_rc = 1'b0
);
    logic [1:0] wake_q = 2'h0;

    always_ff @(posedge clock)
        hw_powerdown_pin <= ~pd_req;
    always_ff @(posedge clock)
        watchdog_enable_pin <= wden_req;
    always_ff @(posedge clock)
        osc_below_rc <= osc_bad;
    // short low pulse, two cycles, then released high
    always_ff @(posedge clock)
    begin
        wake_q <= {wake_q[0], wake_req};
        ext_irq0_wake_pin <= ~(wake_req & ~wake_q[1]);
    end
endmodule

// >>> testbench/tb.sv
// self-checking bench for the watchdog and power mode block
`timescale 1ns/1ns
`include "wdpm_map.svh"
module tb
    import wdpm_pkg::*;
;
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    wb_req_t     req = '0;
    logic        wb_ack;
    logic [31:0] wb_dat_o;
    logic        irq = 1'b0;
    logic        pd_req = 1'b0;
    logic        wake_req = 1'b0;
    logic        wden_req = 1'b0;
    logic        osc_bad = 1'b0;
    logic        hw_powerdown_pin_pin;
    logic        wake_pin;
    logic        wden_pin;
    logic        osc_pin;
    power_out_t  pout;
    int          n_mismatch = 0;
    int          check_count = 0;
    int          cycles = 0;
    logic [31:0] v;
    logic [31:0] w;

    watchdog_power_mode_control #(.OSC_EXT_CYCLES(8)) dut_u (.clock(clock), .rst_n(rst_n),
        .wb_req(req), .wb_ack(wb_ack), .wb_dat_o(wb_dat_o), .watchdog_enable_pin(wden_pin),
        .hw_powerdown_pin(hw_powerdown_pin_pin), .ext_irq0_wake_pin(wake_pin), .periph_irq(irq),
        .osc_below_rc(osc_pin), .power_out(pout));
    board_model board_u (.clock(clock), .pd_req(pd_req), .wake_req(wake_req),
        .wden_req(wden_req), .osc_bad(osc_bad), .hw_powerdown_pin(hw_powerdown_pin_pin),
        .ext_irq0_wake_pin(wake_pin), .watchdog_enable_pin(wden_pin), .osc_below_rc(osc_pin));

    initial
        forever #20 clock = ~clock;

    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // the whole run needs about 8500 cycles
    always @(posedge clock)
    begin
        cycles++;
        if (cycles > 30000)
        begin
            n_mismatch++;
            $display("ERROR timeout expected 0 seen %0d", cycles);
            end_sim;
        end
    end

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    // hold the request until ack is sampled high
    task automatic bus(input logic we, input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        req <= '{1'b1, 1'b1, we, a, 4'hF, {24'h0, d}};
        // no local limit: only the bench timeout may end this wait
        do
        begin
            @(posedge clock);
        end
        while (wb_ack !== 1'b1);
        v = wb_dat_o;
        req <= '0;
    endtask

    task automatic ticks(input int n);
        repeat (n) @(posedge clock);
    endtask

    task automatic wait_sys(input logic lv, input int lim);
        int k;
        k = 0;
        while (pout.sys_reset !== lv && k < lim)
        begin
            @(posedge clock);
            k++;
        end
        chk("sys_reset", lv, pout.sys_reset);
    endtask

    task automatic cnt_en(input int n, input int ec, input int ep);
        int c;
        int p;
        c = 0;
        p = 0;
        repeat (n)
        begin
            @(posedge clock);
            c += pout.cpu_clk_en;
            p += pout.periph_clk_en;
        end
        chk("cpu_en", ec, c);
        chk("periph_en", ep, p);
    endtask

    task automatic irq_pulse;
        @(posedge clock);
        irq <= 1'b1;
        @(posedge clock);
        irq <= 1'b0;
        ticks(2);
    endtask

    task automatic refresh;
        bus(1, `ADR_WD_CTRL, 8'h01);
        bus(1, `ADR_WD_CTRL, 8'h02);
    endtask

    task automatic t_regs;
        bus(0, `ADR_POWER_CTRL, 0);
        chk("pc_reset", `RST_POWER_CTRL, v);
        bus(0, 8'h14, 0);
        chk("unmapped", 0, v);
        bus(1, `ADR_WD_RELOAD, 8'h85);
        bus(0, `ADR_WD_RELOAD, 0);
        chk("reload", 32'h85, v);
        $display("test regs done");
    endtask

    task automatic t_wd;
        bus(1, `ADR_WD_CTRL, 8'h02);
        bus(0, `ADR_WD_CTRL, 0);
        chk("running", 1, v[2]);
        bus(1, `ADR_WD_CTRL, 8'h01);
        bus(0, `ADR_POWER_CTRL, 0);
        bus(1, `ADR_WD_CTRL, 8'h02);
        bus(0, `ADR_WD_COUNT, 0);
        chk("no_refresh", 0, v[14:8]);
        refresh;
        bus(0, `ADR_WD_COUNT, 0);
        chk("refresh", 5, v[14:8]);
        chk("low_bits", 0, v[7:1]);
        bus(1, `ADR_POWER_CTRL, 8'h01);
        bus(1, `ADR_POWER_CTRL, 8'h20);
        bus(0, `ADR_WD_COUNT, 0);
        w = v;
        cnt_en(800, 0, 800);
        bus(0, `ADR_WD_COUNT, 0);
        chk("frozen", w, v);
        bus(0, `ADR_STATUS, 0);
        chk("idle_flag", 1, v[5]);
        irq_pulse;
        bus(0, `ADR_STATUS, 0);
        chk("idle_exit", 0, v[5]);
        ticks(800);
        bus(0, `ADR_WD_COUNT, 0);
        chk("counting", 1, v > w);
        bus(1, `ADR_WD_RELOAD, 8'h00);
        refresh;
        ticks(240);
        bus(0, `ADR_WD_COUNT, 0);
        chk("rate24", 1, v >= 9 && v <= 11);
        bus(1, `ADR_WD_RELOAD, 8'h7F);
        refresh;
        ticks(6000);
        chk("early", 0, pout.sys_reset);
        wait_sys(1'b1, 400);
        chk("rst_gate", 0, pout.cpu_clk_en);
        wait_sys(1'b0, 200);
        bus(0, `ADR_WD_CTRL, 0);
        chk("cause_wd", 1, v[3]);
        chk("stopped", 0, v[2]);
        $display("test watchdog done");
    endtask

    task automatic t_osc;
        int k;
        wden_req <= 1'b1;
        ticks(3);
        bus(0, `ADR_WD_CTRL, 0);
        chk("pin_start", 1, v[2]);
        wden_req <= 1'b0;
        ticks(3);
        bus(0, `ADR_WD_CTRL, 0);
        chk("no_stop", 1, v[2]);
        osc_bad <= 1'b1;
        ticks(3);
        chk("osc_reset", 1, pout.sys_reset);
        chk("rc_sel", 1, pout.rc_clock_sel);
        osc_bad <= 1'b0;
        k = 0;
        while (pout.rc_clock_sel === 1'b1 && k < 100)
        begin
            @(posedge clock);
            k++;
        end
        chk("extend", 1, k >= 8 && k <= 13);
        ticks(1);
        bus(0, `ADR_WD_CTRL, 0);
        chk("cause_osc", 0, v[3]);
        $display("test oscillator done");
    endtask

    task automatic t_slow;
        bus(1, `ADR_POWER_CTRL, 8'h10);
        cnt_en(80, 10, 10);
        bus(1, `ADR_POWER_CTRL, 8'h01);
        bus(1, `ADR_POWER_CTRL, 8'h30);
        cnt_en(80, 0, 10);
        irq_pulse;
        bus(1, `ADR_POWER_CTRL, 8'h00);
        cnt_en(80, 80, 80);
        $display("test slow done");
    endtask

    task automatic t_pd;
        bus(1, `ADR_POWER_CTRL, 8'h02);
        bus(1, `ADR_POWER_CTRL, 8'h40);
        ticks(1);
        chk("osc_stop", 1, pout.osc_stop);
        wake_req <= 1'b1;
        ticks(6);
        wake_req <= 1'b0;
        chk("woken", 0, pout.osc_stop);
        pd_req <= 1'b1;
        ticks(30);
        chk("float", 1, pout.port_float);
        chk("hw_stop", 1, pout.osc_stop);
        pd_req <= 1'b0;
        ticks(3);
        chk("unfloat", 0, pout.port_float);
        chk("rc_restart", 1, pout.rc_clock_sel);
        wait_sys(1'b0, 100);
        $display("test power down done");
    endtask

    initial
    begin
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        wait_sys(1'b0, 200);
        t_regs;
        t_wd;
        t_osc;
        t_slow;
        t_pd;
        end_sim;
    end
endmodule

bind watchdog_power_mode_control wdpm_sva #(.OSC_EXT_CYCLES(OSC_EXT_CYCLES)) sva_u (
    .clock(clock), .rst_n(rst_n), .wb_req(wb_req), .wb_ack(wb_ack), .wb_dat_o(wb_dat_o),
    .watchdog_enable_pin(watchdog_enable_pin), .hw_powerdown_pin(hw_powerdown_pin),
    .ext_irq0_wake_pin(ext_irq0_wake_pin), .periph_irq(periph_irq),
    .osc_below_rc(osc_below_rc), .power_out(power_out));
